/* File: logic/lcrb_regs.sv */
// LIN controller register bank: direct configuration, index and port
// registers, the fifteen indirect core registers and a receive FIFO.
// Assumes the processor and the frame engine run on core_clk_in.
`include "lcrb_map.svh"

// Small first-in first-out buffer with valid/ready on both sides
module lcrb_fifo
  import lcrb_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic clk_en_in,
  input wire logic flush_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  // Full and empty follow the occupancy count directly
  assign in_ready_out = (count_reg != (AW+1)'(DEPTH));
  assign out_valid_out = (count_reg != '0);
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;
  assign out_data_out = mem_reg[rd_ptr_reg];

  // Storage array, no reset needed for the words themselves
  always_ff @(posedge core_clk_in) begin
    if (clk_en_in && push) begin
      mem_reg[wr_ptr_reg] <= in_data_in;
    end
  end

  // Pointers wrap at DEPTH so a non power of two depth also works
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else if (clk_en_in) begin
      if (flush_in) begin
        wr_ptr_reg <= '0;
        rd_ptr_reg <= '0;
        count_reg <= '0;
      end else begin
        if (push) begin
          wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
        end
        if (pop) begin
          rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
        end
        if (push && !pop) begin
          count_reg <= count_reg + 1'b1;
        end else if (pop && !push) begin
          count_reg <= count_reg - 1'b1;
        end
      end
    end
  end
endmodule

// Register bank top
module lcrb_regs
  import lcrb_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic clk_en_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [7:0] sfr_wdata_in,
  output logic [7:0] sfr_rdata_out,
  input wire lcrb_evt_t evt_in,
  input wire logic rx_valid_in,
  output logic rx_ready_out,
  input wire logic [7:0] rx_byte_in,
  output lcrb_cfg_t cfg_out,
  output lcrb_cmd_t cmd_out,
  output lcrb_setup_t setup_out,
  output logic [63:0] payload_out
);

  logic [7:0] cfg_reg;
  logic [7:0] index_reg;
  logic [7:0] rdata_reg;
  logic [7:0] data_reg [8];
  logic [7:0] ctrl_reg;
  logic [7:0] status_reg;
  logic [4:0] error_reg;
  logic [7:0] size_reg;
  logic [7:0] div_reg;
  logic [7:0] mul_reg;
  logic [5:0] id_reg;
  logic [2:0] rx_slot_reg;
  logic halt_reg;
  logic ack_pulse_reg;

  logic on;
  logic master;
  logic slave;
  logic port_wr;
  logic port_rd;
  logic ctrl_wr;
  logic data_wr;
  logic [7:0] ev_ctrl;
  logic [7:0] rd_core;
  logic [7:0] rd_sfr;
  logic [7:0] st_view;
  logic [4:0] err_view;
  logic [4:0] err_evt;
  logic irq_evt;
  logic frame_start;
  logic drain_valid;
  logic drain_ready;
  logic [7:0] drain_byte;

  // Role and enable decode used throughout
  assign on = cfg_reg[`LCRB_CFG_ON];
  assign master = cfg_reg[`LCRB_CFG_MASTER];
  assign slave = ~master;

  // Indirect port strobes target the register the index selects (see RQ17)
  assign port_wr = sfr_wr_in && (sfr_addr_in == `LCRB_SFR_PORT);
  assign port_rd = sfr_rd_in && (sfr_addr_in == `LCRB_SFR_PORT);
  assign ctrl_wr = port_wr && (index_reg == `LCRB_IX_CTRL);
  assign data_wr = port_wr && (index_reg <= `LCRB_IX_DATA_LAST);

  // Engine events count only while the interface is on (see RQ1)
  assign err_evt = on ? evt_in.err_set : 5'h00;
  assign frame_start = on & (evt_in.tx_start | evt_in.id_received);
  assign irq_evt = on & (evt_in.id_received | evt_in.done | (|evt_in.err_set)
                   | evt_in.idle_timeout | evt_in.wakeup_seen
                   | (master & evt_in.wakeup_sent));

  // Direct configuration register; low bits never store (see RQ4)
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cfg_reg <= `LCRB_CFG_RESET;
    end else if (clk_en_in && sfr_wr_in && (sfr_addr_in == `LCRB_SFR_CFG)) begin
      cfg_reg <= {sfr_wdata_in[7:5], 5'h00}; // see RQ4
    end
  end

  // Index register for the indirect port
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      index_reg <= 8'h00;
    end else if (clk_en_in && sfr_wr_in && (sfr_addr_in == `LCRB_SFR_INDEX)) begin
      index_reg <= sfr_wdata_in; // see RQ17
    end
  end

  // Eight data byte registers, written by software or by the receive drain
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_data
      always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          data_reg[gi] <= 8'h00;
        end else if (clk_en_in) begin
          if (data_wr && (index_reg[2:0] == 3'(gi))) begin
            data_reg[gi] <= sfr_wdata_in; // see RQ7
          end else if (drain_valid && drain_ready && (rx_slot_reg == 3'(gi))) begin
            data_reg[gi] <= drain_byte; // see RQ7
          end
        end
      end
      assign payload_out[gi*8 +: 8] = data_reg[gi];
    end
  endgenerate

  // Received bytes wait in the FIFO; a software data write stalls the
  // drain for that cycle so the two never collide on one byte register
  assign drain_ready = ~data_wr;

  lcrb_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .core_clk_in(core_clk_in),
    .rst_b_in(rst_b_in),
    .clk_en_in(clk_en_in),
    .flush_in(~on),
    .in_valid_in(rx_valid_in & on),
    .in_ready_out(rx_ready_out),
    .in_data_in(rx_byte_in),
    .out_valid_out(drain_valid),
    .out_ready_in(drain_ready),
    .out_data_out(drain_byte)
  );

  // Receive slot restarts at byte 0 with each new frame
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rx_slot_reg <= 3'h0;
    end else if (clk_en_in) begin
      if (frame_start) begin
        rx_slot_reg <= 3'h0;
      end else if (drain_valid && drain_ready) begin
        rx_slot_reg <= rx_slot_reg + 3'h1;
      end
    end
  end

  // Hardware clears on the held control bits
  always_comb begin
    ev_ctrl = 8'h00;
    // Launch ends on completion or on any error (see RQ15)
    ev_ctrl[`LCRB_CT_LAUNCH] = on & (evt_in.done | (|evt_in.err_set));
    // Wakeup request ends once the signal has gone out (see RQ14)
    ev_ctrl[`LCRB_CT_ROUSE] = on & (evt_in.wakeup_sent | (|evt_in.err_set));
  end

  // Control register: held bits, with role gating on software writes
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl_reg <= 8'h00;
    end else if (clk_en_in) begin
      if (ctrl_wr) begin
        // Slave-only bits ignore writes in master role (see RQ6)
        if (slave) begin
          ctrl_reg[`LCRB_CT_SLEEP] <= sfr_wdata_in[`LCRB_CT_SLEEP]; // see RQ9
        end
        ctrl_reg[`LCRB_CT_DIR] <= sfr_wdata_in[`LCRB_CT_DIR]; // see RQ10
        // Master-only start bit ignores writes in slave role (see RQ6)
        if (master && sfr_wdata_in[`LCRB_CT_LAUNCH] && !status_reg[`LCRB_ST_ERROR]) begin
          ctrl_reg[`LCRB_CT_LAUNCH] <= 1'b1; // see RQ15
        end
        if (sfr_wdata_in[`LCRB_CT_ROUSE] && !status_reg[`LCRB_ST_ERROR]) begin
          ctrl_reg[`LCRB_CT_ROUSE] <= 1'b1; // see RQ14
        end
      end
      // A clear event in the cycle of a new set defers to the set
      if (ev_ctrl[`LCRB_CT_LAUNCH] && !(ctrl_wr && sfr_wdata_in[`LCRB_CT_LAUNCH])) begin
        ctrl_reg[`LCRB_CT_LAUNCH] <= 1'b0; // see RQ15
      end
      if (ev_ctrl[`LCRB_CT_ROUSE] && !(ctrl_wr && sfr_wdata_in[`LCRB_CT_ROUSE])) begin
        ctrl_reg[`LCRB_CT_ROUSE] <= 1'b0; // see RQ14
      end
      // Write-only action bits are never stored
      ctrl_reg[`LCRB_CT_HALT] <= 1'b0; // see RQ8
      ctrl_reg[`LCRB_CT_ACK] <= 1'b0; // see RQ11
      ctrl_reg[`LCRB_CT_IRQCLR] <= 1'b0; // see RQ12
      ctrl_reg[`LCRB_CT_FLTCLR] <= 1'b0; // see RQ13
    end
  end

  // Acknowledge is a one-cycle pulse; the bit clears itself next edge
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ack_pulse_reg <= 1'b0;
    end else if (clk_en_in) begin
      ack_pulse_reg <= ctrl_wr & slave & sfr_wdata_in[`LCRB_CT_ACK]; // see RQ11
    end
  end

  // Halt holds until the engine sees the next break (id or start event) or the interface goes off
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      halt_reg <= 1'b0;
    end else if (clk_en_in) begin
      if (ctrl_wr && slave && sfr_wdata_in[`LCRB_CT_HALT]) begin
        halt_reg <= 1'b1; // see RQ8
      end else if (frame_start || !on) begin
        halt_reg <= 1'b0; // see RQ8
      end
    end
  end

  // Status flags: hardware sets win over software clears in one cycle
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      status_reg <= 8'h00;
    end else if (clk_en_in) begin
      status_reg[`LCRB_ST_ACTIVE] <= on & evt_in.active;
      if (on && evt_in.tx_start) begin
        status_reg[`LCRB_ST_DONE] <= 1'b0; // see RQ18
      end
      if (on && (evt_in.done || evt_in.wakeup_seen || (master && evt_in.wakeup_sent))) begin
        status_reg[`LCRB_ST_DONE] <= 1'b1; // see RQ18
      end
      if (irq_evt) begin
        status_reg[`LCRB_ST_IRQ] <= 1'b1;
      end else if (ctrl_wr && sfr_wdata_in[`LCRB_CT_IRQCLR]) begin
        status_reg[`LCRB_ST_IRQ] <= 1'b0; // see RQ12
      end
      if (err_evt != 5'h00) begin
        status_reg[`LCRB_ST_ERROR] <= 1'b1; // see RQ19
      end else if (ctrl_wr && sfr_wdata_in[`LCRB_CT_FLTCLR]) begin
        status_reg[`LCRB_ST_ERROR] <= 1'b0; // see RQ13
      end
      if (on && evt_in.id_received) begin
        status_reg[`LCRB_ST_IDREQ] <= 1'b1;
      end else if (ack_pulse_reg || (ctrl_wr && sfr_wdata_in[`LCRB_CT_HALT])) begin
        status_reg[`LCRB_ST_IDREQ] <= 1'b0;
      end
      if ((on && evt_in.abort) || (ctrl_wr && slave && sfr_wdata_in[`LCRB_CT_HALT])) begin
        status_reg[`LCRB_ST_ABORT] <= 1'b1; // see RQ8
      end else if (frame_start) begin
        status_reg[`LCRB_ST_ABORT] <= 1'b0;
      end
      if (on && evt_in.idle_timeout) begin
        status_reg[`LCRB_ST_IDLE] <= 1'b1;
      end else if (frame_start || ctrl_reg[`LCRB_CT_SLEEP]) begin
        status_reg[`LCRB_ST_IDLE] <= 1'b0;
      end
      if (on && (evt_in.wakeup_seen || evt_in.wakeup_sent)) begin
        status_reg[`LCRB_ST_WAKE] <= 1'b1;
      end else if (frame_start) begin
        status_reg[`LCRB_ST_WAKE] <= 1'b0;
      end
    end
  end

  // Error register: sticky per cause; writes through the port do nothing
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      error_reg <= 5'h00;
    end else if (clk_en_in) begin
      if (ctrl_wr && sfr_wdata_in[`LCRB_CT_FLTCLR]) begin
        error_reg <= err_evt; // see RQ13
      end else begin
        error_reg <= error_reg | err_evt; // see RQ19
      end
    end
  end

  // Frame and rate setup registers
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      size_reg <= 8'h00;
      div_reg <= 8'h00;
      mul_reg <= 8'h00;
      id_reg <= 6'h00;
    end else if (clk_en_in && port_wr) begin
      unique case (index_reg)
        `LCRB_IX_SIZE: size_reg <= {sfr_wdata_in[7], 3'h0, sfr_wdata_in[3:0]};
        `LCRB_IX_DIV: div_reg <= sfr_wdata_in;
        `LCRB_IX_MUL: mul_reg <= sfr_wdata_in;
        `LCRB_IX_ID: id_reg <= sfr_wdata_in[5:0];
        default: ;
      endcase
    end
  end

  // Read views hide bits of the other role (see RQ6)
  always_comb begin
    st_view = status_reg;
    err_view = error_reg;
    if (master) begin
      st_view[`LCRB_ST_IDLE] = 1'b0;
      st_view[`LCRB_ST_ABORT] = 1'b0;
      st_view[`LCRB_ST_IDREQ] = 1'b0;
      err_view = error_reg & ~`LCRB_ERR_SLAVE_MASK;
    end
  end

  // Indirect read mux; status and error have no write path (see RQ20)
  always_comb begin
    rd_core = `LCRB_ZERO;
    if (index_reg <= `LCRB_IX_DATA_LAST) begin
      rd_core = data_reg[index_reg[2:0]];
    end else begin
      unique case (index_reg)
        `LCRB_IX_CTRL: begin
          rd_core = ctrl_reg;
          rd_core[`LCRB_CT_SLEEP] = slave & ctrl_reg[`LCRB_CT_SLEEP];
          rd_core[`LCRB_CT_LAUNCH] = master & ctrl_reg[`LCRB_CT_LAUNCH];
        end
        `LCRB_IX_STATUS: rd_core = st_view;
        `LCRB_IX_ERROR: rd_core = {3'h0, err_view};
        `LCRB_IX_SIZE: rd_core = size_reg;
        `LCRB_IX_DIV: rd_core = div_reg;
        `LCRB_IX_MUL: rd_core = mul_reg;
        `LCRB_IX_ID: rd_core = {2'h0, id_reg};
        default: rd_core = `LCRB_ZERO; // see RQ5
      endcase
    end
  end

  // Direct read mux; an unknown address reads zero
  always_comb begin
    unique case (sfr_addr_in)
      `LCRB_SFR_CFG: rd_sfr = cfg_reg; // see RQ4
      `LCRB_SFR_INDEX: rd_sfr = index_reg;
      `LCRB_SFR_PORT: rd_sfr = rd_core; // see RQ17
      default: rd_sfr = `LCRB_ZERO;
    endcase
  end

  // Read data is registered: it appears one edge after the read strobe
  // and holds until the next read
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_reg <= 8'h00;
    end else if (clk_en_in && sfr_rd_in) begin
      rdata_reg <= rd_sfr;
    end
  end

  assign sfr_rdata_out = rdata_reg;

  // Configuration toward the engine (see RQ1, RQ2)
  assign cfg_out.interface_on = on; // see RQ1
  assign cfg_out.master = master; // see RQ2
  // Automatic rate detection only counts in slave role
  assign cfg_out.auto_rate_detect = slave & cfg_reg[`LCRB_CFG_AUTO]; // see RQ3

  // Commands toward the engine, all forced off while disabled
  assign cmd_out.halt = on & halt_reg; // see RQ8
  assign cmd_out.sleep = on & slave & ctrl_reg[`LCRB_CT_SLEEP]; // see RQ9
  assign cmd_out.frame_direction = on & ctrl_reg[`LCRB_CT_DIR]; // see RQ10
  assign cmd_out.data_request_ack = on & ack_pulse_reg; // see RQ11
  assign cmd_out.send_rouse_signal = on & ctrl_reg[`LCRB_CT_ROUSE]; // see RQ14
  assign cmd_out.frame_launch = on & master & ctrl_reg[`LCRB_CT_LAUNCH]; // see RQ15

  // Frame setup toward the engine
  assign setup_out.checksum_type_select = size_reg[`LCRB_SZ_CHK];
  assign setup_out.payload_length = size_reg[3:0];
  assign setup_out.rate_divisor_low = div_reg;
  assign setup_out.multiplier_prescaler = mul_reg;
  assign setup_out.frame_identifier = id_reg;

endmodule

/* File: logic/lcrb_map.svh */
// Register map, field positions, reset values and widths of the LIN
// controller register bank. Assumes inclusion by the bank's design file.
//
// Behaviour
// RQ1: Configuration bit 7 disables the controller when 0, enables it when 1.
// RQ2: Configuration bit 6 selects slave role at 0, master role at 1.
// RQ3: Configuration bit 5 picks automatic rate detect; ignored in master role.
// RQ4: Configuration bits 4 to 0 read zero and ignore writes.
// RQ5: Fifteen indirect core registers at indices 0x00 to 0x0e.
// RQ6: Master-only bits reachable only as master, slave-only bits only as slave.
// RQ7: Eight data byte registers hold received or to-be-sent bytes.
// RQ8: Control bit 7 write 1 halts processing until next break; reads 0.
// RQ9: Control bit 6 requests slave bus sleep at 1, waking at 0.
// RQ10: Control bit 5 marks frame as receive at 0, transmit at 1.
// RQ11: Slave sets control bit 4 after data request; controller clears it.
// RQ12: Control bit 3 write 1 clears interrupt pending flag; reads 0.
// RQ13: Control bit 2 write 1 clears error status and error register; reads 0.
// RQ14: Control bit 1 sends wakeup signal; controller clears it itself.
// RQ15: Control bit 0 starts master frame; cleared on completion or error.
// RQ16: Software sets start only after identifier, length and data are loaded.
// RQ17: Indirect data port accesses the core register the index selects.
// RQ18: Status bit 0 clears at transmission start, sets at its completion.
// RQ19: Status bit 2 sets on any error and holds until error clear.
// RQ20: Writes to status and error registers change nothing.
`ifndef LCRB_MAP_SVH
`define LCRB_MAP_SVH

// Direct special function addresses
`define LCRB_SFR_CFG 8'hc9
`define LCRB_SFR_INDEX 8'hd3
`define LCRB_SFR_PORT 8'hd2

// Indirect core register indices
`define LCRB_IX_DATA_LAST 8'h07
`define LCRB_IX_CTRL 8'h08
`define LCRB_IX_STATUS 8'h09
`define LCRB_IX_ERROR 8'h0a
`define LCRB_IX_SIZE 8'h0b
`define LCRB_IX_DIV 8'h0c
`define LCRB_IX_MUL 8'h0d
`define LCRB_IX_ID 8'h0e

// Configuration fields and reset value
`define LCRB_CFG_ON 7
`define LCRB_CFG_MASTER 6
`define LCRB_CFG_AUTO 5
`define LCRB_CFG_RESET 8'h60

// Control fields
`define LCRB_CT_HALT 7
`define LCRB_CT_SLEEP 6
`define LCRB_CT_DIR 5
`define LCRB_CT_ACK 4
`define LCRB_CT_IRQCLR 3
`define LCRB_CT_FLTCLR 2
`define LCRB_CT_ROUSE 1
`define LCRB_CT_LAUNCH 0

// Status fields
`define LCRB_ST_ACTIVE 7
`define LCRB_ST_IDLE 6
`define LCRB_ST_ABORT 5
`define LCRB_ST_IDREQ 4
`define LCRB_ST_IRQ 3
`define LCRB_ST_ERROR 2
`define LCRB_ST_WAKE 1
`define LCRB_ST_DONE 0

// Error register: bits 4 and 3 are slave-only
`define LCRB_ERR_SLAVE_MASK 5'h18
// Size register: checksum type and length
`define LCRB_SZ_CHK 7
`define LCRB_ID_MASK 8'h3f
`define LCRB_ZERO 8'h00

`endif

/* File: logic/lcrb_pkg.sv */
// Types shared by the LIN controller register bank and its users.
// Assumes the frame engine sits on the same clock as the bank.
package lcrb_pkg;

  // Configuration seen by the frame engine
  typedef struct packed {
    logic interface_on;
    logic master;
    logic auto_rate_detect;
  } lcrb_cfg_t;

  // Events reported by the frame engine, one-cycle pulses except active
  typedef struct packed {
    logic active;
    logic idle_timeout;
    logic abort;
    logic id_received;
    logic tx_start;
    logic done;
    logic wakeup_seen;
    logic wakeup_sent;
    logic [4:0] err_set;
  } lcrb_evt_t;

  // Commands handed to the frame engine
  typedef struct packed {
    logic halt;
    logic sleep;
    logic frame_direction;
    logic data_request_ack;
    logic send_rouse_signal;
    logic frame_launch;
  } lcrb_cmd_t;

  // Frame and rate settings handed to the frame engine
  typedef struct packed {
    logic checksum_type_select;
    logic [3:0] payload_length;
    logic [7:0] rate_divisor_low;
    logic [7:0] multiplier_prescaler;
    logic [5:0] frame_identifier;
  } lcrb_setup_t;

endpackage

/* File: test/lcrb_regs_properties.sv */
// Port checker of the register bank: reads, role gating, self-clearing bits.
// Assumes binding to lcrb_regs; the index is shadowed from bus writes.
`include "lcrb_map.svh"
module lcrb_regs_chk
  import lcrb_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic clk_en_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic [7:0] sfr_rdata_out,
  input wire lcrb_evt_t evt_in,
  input wire logic rx_valid_in,
  input wire logic rx_ready_out,
  input wire logic [7:0] rx_byte_in,
  input wire lcrb_cfg_t cfg_out,
  input wire lcrb_cmd_t cmd_out,
  input wire lcrb_setup_t setup_out,
  input wire logic [63:0] payload_out
);
  logic [7:0] idx_reg;
  logic rd_port;
  logic wr_cfg;
  // Shadow index, so port reads can be decoded here
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in)
      idx_reg <= 8'h00;
    else if (clk_en_in && sfr_wr_in && sfr_addr_in == `LCRB_SFR_INDEX)
      idx_reg <= sfr_wdata_in;
  end
  // Taken accesses
  assign rd_port = clk_en_in && sfr_rd_in && sfr_addr_in == `LCRB_SFR_PORT;
  assign wr_cfg = clk_en_in && sfr_wr_in && sfr_addr_in == `LCRB_SFR_CFG;

  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);

  off_quiet_a: assert property (!cfg_out.interface_on |-> cmd_out == '0)
    else $error("commands while off");
  cfg_write_a: assert property (wr_cfg |=> cfg_out.interface_on == $past(sfr_wdata_in[7])
    && cfg_out.master == $past(sfr_wdata_in[6])) else $error("config not taken");
  auto_role_a: assert property (cfg_out.auto_rate_detect |-> !cfg_out.master)
    else $error("auto rate in master");
  cfg_unused_a: assert property (clk_en_in && sfr_rd_in && sfr_addr_in == `LCRB_SFR_CFG
    |=> sfr_rdata_out[4:0] == 5'h00) else $error("config low bits set");
  ctrl_wo_a: assert property (rd_port && idx_reg == `LCRB_IX_CTRL
    |=> sfr_rdata_out[7] == 1'b0 && sfr_rdata_out[3:2] == 2'b00) else $error("ctrl bits read");
  ack_pulse_a: assert property ($rose(cmd_out.data_request_ack) && clk_en_in
    |=> !cmd_out.data_request_ack) else $error("ack not cleared");
  launch_end_a: assert property (clk_en_in && !sfr_wr_in && cmd_out.frame_launch
    && (evt_in.done || |evt_in.err_set) |=> !cmd_out.frame_launch) else $error("start kept");
  rouse_end_a: assert property (clk_en_in && !sfr_wr_in && cmd_out.send_rouse_signal
    && evt_in.wakeup_sent |=> !cmd_out.send_rouse_signal) else $error("wakeup kept");
  read_hold_a: assert property (!(clk_en_in && sfr_rd_in) |=> $stable(sfr_rdata_out))
    else $error("read data moved");
  ident_read_a: assert property (rd_port && idx_reg == `LCRB_IX_ID
    |=> sfr_rdata_out[7:6] == 2'b00) else $error("identifier top bits");
endmodule

bind lcrb_regs lcrb_regs_chk #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (.*);

/* File: test/lcrb_engine_model.sv */
// Frame engine stand-in: answers launches and wakeup requests.
// Assumes the bank clock; latency and failure are set by the bench.
module lcrb_engine_model
  import lcrb_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire lcrb_cmd_t cmd_in,
  input wire logic [7:0] lat_in,
  input wire logic fail_in,
  output lcrb_evt_t evt_out
);
  logic [7:0] cnt_reg;
  // Events other than active are one-cycle pulses; a held request is not answered twice
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      evt_out <= '0;
      cnt_reg <= 8'h00;
    end else begin
      evt_out.tx_start <= 1'b0;
      evt_out.done <= 1'b0;
      evt_out.err_set <= 5'h00;
      evt_out.wakeup_sent <= cmd_in.send_rouse_signal && !evt_out.wakeup_sent;
      if (evt_out.active) begin
        cnt_reg <= cnt_reg - 8'h01;
        if (cnt_reg == 8'h00) begin
          evt_out.active <= 1'b0;
          evt_out.done <= !fail_in;
          evt_out.err_set <= {2'b00, fail_in, 2'b00};
        end
      end else if (cmd_in.frame_launch && !evt_out.done && evt_out.err_set == 5'h00) begin
        evt_out.active <= 1'b1;
        evt_out.tx_start <= 1'b1;
        cnt_reg <= lat_in;
      end
    end
  end
endmodule

/* File: test/tb_top.sv */
// Self-checking bench of the register bank with an engine model.
// Assumes one 25 MHz clock; bytes are pushed by the bench itself.
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin err_count++; \
  $display("wrong value %s exp %h got %h", n, e, a); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk_in = 1'b0, rst_b_in = 1'b0, clk_en_in = 1'b1, rx_ready_out;
  logic sfr_wr_in = 1'b0, sfr_rd_in = 1'b0, rx_valid_in = 1'b0, fail = 1'b0;
  logic [7:0] sfr_addr_in = 8'h00, sfr_wdata_in = 8'h00, rx_byte_in = 8'h00;
  logic [7:0] lat = 8'h01, sfr_rdata_out, v;
  logic [63:0] payload_out;
  lcrb_pkg::lcrb_evt_t evt_in;
  lcrb_pkg::lcrb_cfg_t cfg_out;
  lcrb_pkg::lcrb_cmd_t cmd_out;
  lcrb_pkg::lcrb_setup_t setup_out;
  int err_count = 0, checks = 0;
  // 40 ns period
  always #20 core_clk_in = ~core_clk_in;
  lcrb_regs #(.FIFO_DEPTH(4)) DUT (.*);
  lcrb_engine_model u_eng (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
    .cmd_in(cmd_out), .lat_in(lat), .fail_in(fail), .evt_out(evt_in));
  // Bus cycles: strobe for one edge, settle to the falling edge
  task automatic acc(input logic w, input logic [7:0] a, d);
    @(posedge core_clk_in);
    sfr_addr_in <= a;
    sfr_wdata_in <= d;
    if (w) sfr_wr_in <= 1'b1;
    else sfr_rd_in <= 1'b1;
    @(posedge core_clk_in);
    sfr_wr_in <= 1'b0;
    sfr_rd_in <= 1'b0;
    @(negedge core_clk_in);
    v = sfr_rdata_out;
  endtask
  task automatic cw(input logic [7:0] i, d);
    acc(1'b1, 8'hd3, i);
    acc(1'b1, 8'hd2, d);
  endtask
  task automatic cr(input logic [7:0] i);
    acc(1'b1, 8'hd3, i);
    acc(1'b0, 8'hd2, 8'h00);
  endtask
  task automatic s_reset;
    acc(1'b0, 8'hc9, 8'h00);
    `CHK("config", 8'h60, v)
    acc(1'b0, 8'h55, 8'h00);
    `CHK("unmapped", 8'h00, v)
  endtask
  task automatic s_cfg;
    acc(1'b1, 8'hc9, 8'hff);
    acc(1'b0, 8'hc9, 8'h00);
    `CHK("config", 8'he0, v)
    `CHK("auto", 1'b0, cfg_out.auto_rate_detect)
    acc(1'b1, 8'hc9, 8'ha0);
    `CHK("auto", 1'b1, cfg_out.auto_rate_detect)
    @(posedge core_clk_in) clk_en_in <= 1'b0;
    acc(1'b1, 8'hc9, 8'h00);
    @(posedge core_clk_in) clk_en_in <= 1'b1;
    `CHK("on", 1'b1, cfg_out.interface_on)
    acc(1'b1, 8'hc9, 8'h00);
    `CHK("cmd", 6'h00, cmd_out)
  endtask
  task automatic s_data;
    acc(1'b1, 8'hc9, 8'ha0);
    for (int i = 0; i < 8; i++) cw(8'(i), 8'(8'h11 * (i + 1)));
    for (int i = 0; i < 8; i++) begin
      cr(8'(i));
      `CHK("data", 8'(8'h11 * (i + 1)), v)
    end
    `CHK("payload", 64'h8877665544332211, payload_out)
    cr(8'h0f);
    `CHK("hole", 8'h00, v)
    cw(8'h0e, 8'hff);
    cr(8'h0e);
    `CHK("ident", 8'h3f, v)
    cw(8'h09, 8'hff);
    cr(8'h09);
    `CHK("status", 8'h00, v)
  endtask
  task automatic s_slave;
    cw(8'h08, 8'h80);
    `CHK("halt", 1'b1, cmd_out.halt)
    cw(8'h08, 8'h71);
    `CHK("sleep", 1'b1, cmd_out.sleep)
    `CHK("dir", 1'b1, cmd_out.frame_direction)
    `CHK("start", 1'b0, cmd_out.frame_launch)
    cr(8'h08);
    `CHK("ctrl", 8'h60, v)
    acc(1'b1, 8'hc9, 8'he0);
    cr(8'h08);
    `CHK("ctrl", 8'h20, v)
  endtask
  // One master frame; the model answers l+1 cycles after the start, with an error if f
  task automatic s_frame(input logic [7:0] l, input logic f);
    lat = l;
    fail = f;
    cw(8'h0e, 8'h15);
    cw(8'h0b, 8'h02);
    cw(8'h00, 8'h5a);
    `CHK("setup", 10'h095, {setup_out.payload_length, setup_out.frame_identifier})
    cw(8'h08, 8'h21);
    if (l > 8'h05) `CHK("start", 1'b1, cmd_out.frame_launch)
    for (int k = 0; k < 40; k++) begin
      cr(8'h09);
      if (v[0] === 1'b1 || v[2] === 1'b1) break;
    end
    `CHK("status", {!f, 1'b1, f}, {v[0], v[3], v[2]})
    if (f) begin
      cw(8'h0a, 8'h00);
      cr(8'h0a);
      `CHK("error", 8'h04, v)
      cw(8'h08, 8'h21);
      `CHK("start", 1'b0, cmd_out.frame_launch)
      cw(8'h08, 8'h04);
      cr(8'h0a);
      `CHK("error", 8'h00, v)
    end
    cr(8'h08);
    `CHK("start", 1'b0, v[0])
    cw(8'h08, 8'h08);
    cr(8'h09);
    `CHK("irq", 2'b00, {v[3], v[2]})
  endtask
  task automatic s_rx;
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk_in);
      rx_byte_in <= 8'hc0 + 8'(i);
      rx_valid_in <= 1'b1;
      for (int k = 0; k < 20 && rx_ready_out !== 1'b1; k++) @(negedge core_clk_in);
    end
    @(posedge core_clk_in) rx_valid_in <= 1'b0;
    repeat (4) @(negedge core_clk_in);
    `CHK("payload", 64'hc7c6c5c4c3c2c1c0, payload_out)
    `CHK("ready", 1'b1, rx_ready_out)
  endtask
  task automatic s_rouse;
    cw(8'h08, 8'h02);
    cr(8'h08);
    `CHK("rouse", 1'b0, v[1])
    cr(8'h09);
    `CHK("wake", 1'b1, v[1])
  endtask
  task automatic finish_test;
    $display("errors %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog well beyond the few hundred cycles the run needs
  initial begin
    #800000;
    err_count++;
    finish_test;
  end
  initial begin
    repeat (4) @(posedge core_clk_in);
    rst_b_in <= 1'b1;
    s_reset;
    s_cfg;
    s_data;
    s_slave;
    s_frame(8'h01, 1'b0);
    s_rx;
    s_frame(8'h14, 1'b0);
    s_frame(8'h03, 1'b1);
    s_rouse;
    finish_test;
  end
endmodule
